// ===== dv/cpu_store_model.sv
`timescale 1ns/1ps
// cpu store path stand-in
module cpu_store_model (
  input wire logic sys_clk,
  input wire logic cpu_stall,
  output logic store_valid,
  output logic [15:0] store_addr,
  output logic [7:0] store_data
);
  initial begin
    store_valid = 1'b0;
    store_addr = 16'h0000;
    store_data = 8'h00;
  end
  // one-cycle strobe; a stalled core issues nothing
  task automatic issue(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    while (cpu_stall) begin
      @(posedge sys_clk);
      #1;
    end
    store_valid = 1'b1;
    store_addr = a;
    store_data = d;
    @(posedge sys_clk);
    #1;
    store_valid = 1'b0;
    // released bus shows no stale value
    store_addr = ~a;
    store_data = ~d;
  endtask
endmodule // cpu_store_model

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int WR_N = 10;
  localparam int ER_N = 20;
  logic sys_clk, sys_rst, sv, redir, ers, unl, jv, je, irq, busy, stall, irq_o, xw, xs, rx;
  logic [15:0] sa, ja, ra, xa;
  logic [7:0] sd, jd, rdd, xd;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  flash_byte_program_erase #(.WRITE_CYC(WR_N), .ERASE_CYC(ER_N)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .store_valid(sv), .store_addr(sa), .store_data(sd), .extra_select(xs), .store_redirect_enable(redir),
    .page_erase_enable(ers), .software_write_unlock(unl), .jtag_valid(jv), .jtag_erase(je), .jtag_addr(ja),
    .jtag_data(jd), .irq_in(irq), .rd_addr(ra), .rd_extra(rx), .rd_data(rdd), .xram_we(xw), .xram_addr(xa),
    .xram_data(xd), .busy(busy), .cpu_stall(stall), .irq_out(irq_o));
  cpu_store_model cpu_u (.sys_clk(sys_clk), .cpu_stall(stall), .store_valid(sv), .store_addr(sa), .store_data(sd));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // busy length in cycles, stall tracking it
  task automatic op_len(input int n);
    int k;
    k = 0;
    while (busy === 1'b1 && k < 1000) begin
      chk("stall", stall, 1);
      k++;
      @(posedge sys_clk);
      #1;
    end
    chk("busy len", 16'(k), 16'(n));
    chk("stall off", stall, 0);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    ra = a;
    @(posedge sys_clk);
    #1;
    chk("rd", rdd, e);
  endtask
  task automatic jreq(input logic e, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    {jv, je, ja, jd} = {1'b1, e, a, d};
    @(posedge sys_clk);
    #1;
    jv = 1'b0;
  endtask
  // page erase by redirected store, then two programs into one byte
  task automatic t_store;
    {unl, redir, ers} = 3'b111;
    cpu_u.issue(16'h0234, 8'h00);
    op_len(ER_N);
    rd(16'h0200, 8'hFF);
    rd(16'h03FF, 8'hFF);
    ers = 1'b0;
    cpu_u.issue(16'h0210, 8'hA5);
    cpu_u.issue(16'h0210, 8'h3C);
    op_len(WR_N);
    rd(16'h0210, 8'h24);
    $display("store test done");
  endtask
  // extra region erase and program; main byte at the same low address untouched
  task automatic t_extra;
    {xs, ers} = 2'b11;
    cpu_u.issue(16'h0210, 8'h00);
    op_len(ER_N);
    rx = 1'b1;
    rd(16'h0210, 8'hFF);
    ers = 1'b0;
    cpu_u.issue(16'h0210, 8'h96);
    op_len(WR_N);
    rd(16'h0210, 8'h96);
    {xs, rx} = 2'b00;
    rd(16'h0210, 8'h24);
    $display("extra test done");
  endtask
  // locked store dropped, plain store goes to xram
  task automatic t_route;
    unl = 1'b0;
    cpu_u.issue(16'h0211, 8'h00);
    chk("locked busy", busy, 0);
    rd(16'h0211, 8'hFF);
    {unl, redir} = 2'b10;
    cpu_u.issue(16'h1234, 8'h5A);
    chk("xram we", xw, 1);
    chk("xram addr", xa, 16'h1234);
    chk("xram data", xd, 8'h5A);
    chk("xram busy", busy, 0);
    $display("route test done");
  endtask
  // jtag erase and program, interrupt held across a write
  task automatic t_jtag_irq;
    jreq(1'b1, 16'h0400, 8'h00);
    op_len(ER_N);
    rd(16'h05FF, 8'hFF);
    jreq(1'b0, 16'h0401, 8'h81);
    // one-cycle request inside the write, so only the pending flag carries it
    irq = 1'b1;
    @(posedge sys_clk);
    #1;
    irq = 1'b0;
    chk("irq held", irq_o, 0);
    op_len(WR_N - 1);
    chk("irq after", irq_o, 1);
    rd(16'h0401, 8'h81);
    $display("jtag irq test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {sys_rst, redir, ers, unl, jv, je, irq, xs, rx, ja, jd, ra} = {1'b1, 8'h00, 16'h0000, 8'h00, 16'h0000};
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_store();
    t_extra();
    t_route();
    t_jtag_irq();
    print_verdict();
  end
endmodule // testbench

// ===== logic/flash_byte_program_erase.sv
`timescale 1ns/1ps
`include "flash_seq_params.svh"

// Functional notes
// (R1) array of 64k or 32k plus 128 bytes
// (R2) byte program from JTAG or redirected stores
// (R3) program only clears bits to zero
// (R4) erase leaves bytes reading all ones
// (R5) hardware times every operation
// (R6) CPU stalled while operation runs
// (R7) interrupts held until operation completes
// (R8) redirect bit sends stores to array
// (R9) erase bit turns store into page erase
// (R10) software unlock required for store writes
// (R11) erase covers one full 512-byte page
// (R12) busy from accept until timer expiry
module flash_byte_program_erase
  import flash_seq_pkg::*;
#(
  parameter int MAIN_BYTES = `MAIN_BYTES_LARGE,
  parameter int WRITE_CYC = `WRITE_CYCLES,
  parameter int ERASE_CYC = `ERASE_CYCLES,
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // cpu store path
  input wire logic store_valid,
  input wire logic [ADDR_W-1:0] store_addr,
  input wire logic [7:0] store_data,
  input wire logic extra_select,
  // control bits
  input wire logic store_redirect_enable,
  input wire logic page_erase_enable,
  input wire logic software_write_unlock,
  // jtag programming path
  input wire logic jtag_valid,
  input wire logic jtag_erase,
  input wire logic [ADDR_W-1:0] jtag_addr,
  input wire logic [7:0] jtag_data,
  // interrupts from peripherals
  input wire logic irq_in,
  // read port
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic rd_extra,
  output logic [7:0] rd_data,
  // external ram store path, when not redirected
  output logic xram_we,
  output logic [ADDR_W-1:0] xram_addr,
  output logic [7:0] xram_data,
  // status
  output logic busy,
  output logic cpu_stall,
  output logic irq_out
);
  localparam int CNT_W = $clog2(ERASE_CYC + 1);
  localparam int PAGES = MAIN_BYTES / `PAGE_BYTES;
  // one bit wider than the address, so a full 64k array still compares as in range
  localparam logic [ADDR_W:0] MAIN_LIMIT = (ADDR_W+1)'(MAIN_BYTES);

  logic [7:0] main_mem [MAIN_BYTES]; // main array
  logic [7:0] extra_mem [`EXTRA_BYTES]; // extra region
  seq_state_type state_r;
  logic [ADDR_W-1:0] op_addr_r; // latched address
  logic [7:0] op_data_r; // latched data
  logic op_extra_r; // latched region select
  logic irq_pend_r; // held interrupt
  logic sw_go, jt_go, go, go_erase;
  logic timer_load, expired;
  logic [CNT_W-1:0] load_val;

  // software store accepted only when redirected and unlocked
  assign sw_go = store_valid && store_redirect_enable && software_write_unlock; // R8 R10
  // jtag wins when both arrive together
  assign jt_go = jtag_valid; // R2
  assign go = (state_r == st_idle) && (sw_go || jt_go);
  assign go_erase = jt_go ? jtag_erase : page_erase_enable; // R9
  assign timer_load = go;
  assign load_val = go_erase ? CNT_W'(ERASE_CYC) : CNT_W'(WRITE_CYC); // R5

  flash_op_timer #(.CNT_W(CNT_W)) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(timer_load),
    .load_val(load_val),
    .expired(expired)
  );

  // sequencer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= st_idle;
    end else begin
      unique case (state_r)
        st_idle: begin
          if (go) begin
            state_r <= go_erase ? st_erase : st_write;
          end
        end
        st_write, st_erase: begin
          if (expired) begin
            state_r <= st_idle; // R12
          end
        end
        // the fourth code is unused; fall back to idle
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  // latch operands on accept
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_addr_r <= '0;
      op_data_r <= 8'h00;
      op_extra_r <= 1'b0;
    end else if (go) begin
      op_addr_r <= jt_go ? jtag_addr : store_addr;
      op_data_r <= jt_go ? jtag_data : store_data;
      op_extra_r <= jt_go ? 1'b0 : extra_select;
    end
  end

  // array update at end of operation; no reset so it maps to memory
  always_ff @(posedge sys_clk) begin
    if (expired && state_r == st_write) begin
      if (op_extra_r) begin
        extra_mem[op_addr_r[6:0]] <= extra_mem[op_addr_r[6:0]] & op_data_r; // R3
      end else if ({1'b0, op_addr_r} < MAIN_LIMIT) begin
        main_mem[op_addr_r] <= main_mem[op_addr_r] & op_data_r; // R3 R1
      end
    end else if (expired && state_r == st_erase) begin
      if (op_extra_r) begin
        for (int i = 0; i < `EXTRA_BYTES; i++) begin
          extra_mem[i] <= `ERASED_BYTE; // R4
        end
      end else begin
        for (int i = 0; i < `PAGE_BYTES; i++) begin
          // whole page that holds the address
          if ((op_addr_r >> `PAGE_BITS) < ADDR_W'(PAGES)) begin
            main_mem[{op_addr_r[ADDR_W-1:`PAGE_BITS], i[`PAGE_BITS-1:0]}] <= `ERASED_BYTE; // R4 R11
          end
        end
      end
    end
  end

  // registered read port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else if (rd_extra) begin
      rd_data <= extra_mem[rd_addr[6:0]];
    end else begin
      rd_data <= ({1'b0, rd_addr} < MAIN_LIMIT) ? main_mem[rd_addr] : `ERASED_BYTE;
    end
  end

  // stores not redirected go to external ram (default target)
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xram_we <= 1'b0;
      xram_addr <= '0;
      xram_data <= 8'h00;
    end else begin
      xram_we <= store_valid && !store_redirect_enable; // R8
      xram_addr <= store_addr;
      xram_data <= store_data;
    end
  end

  // busy and stall from accept until expiry
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      busy <= go || (busy && !expired); // R12
      cpu_stall <= go || (cpu_stall && !expired); // R6
    end
  end

  // hold interrupts while busy; set wins, released on expiry
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pend_r <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (irq_in && (busy || go)) begin
        irq_pend_r <= 1'b1; // R7
      end else if (!busy) begin
        irq_pend_r <= 1'b0;
      end
      irq_out <= (!busy || expired) && !go && (irq_in || irq_pend_r); // R7 R12
    end
  end

  busy_stall_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    busy == cpu_stall) else $error("stall differs from busy"); // R6
  accept_busy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    go |=> busy) else $error("busy not raised on accept"); // R12
  locked_ignored_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == st_idle && store_valid && !software_write_unlock && !jtag_valid) |=> !busy)
    else $error("locked store started op"); // R10
  write_min_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (go && !go_erase) |=> busy [*8]) else $error("write ended too early"); // R5
  erase_state_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (go && go_erase) |=> state_r == st_erase) else $error("erase not entered"); // R9 R11
  irq_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (busy && !expired) |=> !irq_out) else $error("irq leaked during op"); // R7
  release_same_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    expired |=> (!busy && !cpu_stall)) else $error("release late"); // R12
  xram_default_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (store_valid && !store_redirect_enable) |=> xram_we) else $error("store lost"); // R8
  // held request comes out on the cycle busy falls
  irq_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (expired && (irq_in || irq_pend_r)) |=> irq_out) else $error("held irq not released"); // R7 R12
  write_state_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (go && !go_erase) |=> state_r == st_write) else $error("write not entered"); // R2
endmodule // flash_byte_program_erase

// ===== logic/flash_op_timer.sv
`timescale 1ns/1ps
// down counter timing one array operation
module flash_op_timer #(
  parameter int CNT_W = 20
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  output logic expired
);
  logic [CNT_W-1:0] cnt_r; // remaining cycles

  // load on start, count down to zero and hold there, flag while at one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // one-cycle pulse as the last cycle is reached
  assign expired = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) && !load;
endmodule // flash_op_timer

// ===== pkg/flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
// geometry
`define MAIN_BYTES_LARGE 65536
`define MAIN_BYTES_SMALL 32768
`define EXTRA_BYTES 128
`define PAGE_BYTES 512
`define PAGE_BITS 9
`define ERASED_BYTE 8'hFF
// timing: printed figures and derived cycle counts at 100 MHz
`define CLK_PERIOD_NS 10
`define WRITE_TIME_MIN_US 40
`define ERASE_TIME_MIN_MS 10
`define WRITE_CYCLES ((`WRITE_TIME_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES ((`ERASE_TIME_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== pkg/flash_seq_pkg.sv
package flash_seq_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_write,
    st_erase
  } seq_state_type;
endpackage
